// file: rtl/rsse_defs.svh
// register offsets, field positions and reset values of the execution datapath
// assumes inclusion by bare name from the package and the datapath module
`ifndef RSSE_DEFS_SVH
`define RSSE_DEFS_SVH
`define RSSE_ADDR_W 8
`define RSSE_OFF_OP 8'h00
`define RSSE_OFF_ACC 8'h04
`define RSSE_OFF_MEM 8'h08
`define RSSE_OFF_FLAGS 8'h0C
`define RSSE_OFF_SKIPS 8'h10
`define RSSE_OP_LSB 0
`define RSSE_OP_MSB 2
`define RSSE_BUSY_BIT 4
`define RSSE_C_BIT 0
`define RSSE_AC_BIT 1
`define RSSE_Z_BIT 2
`define RSSE_OV_BIT 3
`define RSSE_ACC_RST 8'h00
`define RSSE_MEM_RST 8'h00
`define RSSE_FLAG_RST 1'b0
`define RSSE_RESP_OKAY 2'h0
`define RSSE_RESP_SLVERR 2'h2
`endif

// file: rtl/rsse_pkg.sv
// types shared by the execution datapath
// assumes rsse_defs.svh on the include path
`include "rsse_defs.svh"
package rsse_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_ROTATE_RIGHT_CARRY_TO_ACC = 3'h1,
        OP_SUB_BORROW_TO_ACC = 3'h2,
        OP_SUB_BORROW_TO_MEM = 3'h3,
        OP_DEC_SKIP_ZERO_MEM = 3'h4,
        OP_DEC_SKIP_ZERO_TO_ACC = 3'h5
    } op_t;
    typedef enum logic [0:0] {
        FSM_IDLE = 1'b0,
        FSM_DUMMY = 1'b1
    } fsm_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [`RSSE_ADDR_W-1:0] awaddr;
        logic [7:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] accumulator;
        logic [7:0] mem;
        logic carry_flag;
        logic aux_carry_flag;
        logic zero_flag;
        logic overflow_flag;
        op_t op;
        fsm_t fsm;
        logic skip_req;
        logic dummy_cycle;
        logic mem_wr_en;
        logic acc_wr_en;
        logic [7:0] skip_count;
    } state_t;
endpackage

// file: rtl/rotate_subtract_skip_exec.sv
// execution datapath for rotate-through-carry, subtract-with-borrow and decrement-skip
// assumes one 10 MHz clock, an axi4-lite master, and a sequencer that reads skip_req
`timescale 1ns/1ps
`include "rsse_defs.svh"
`default_nettype none
module rotate_subtract_skip_exec (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`RSSE_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`RSSE_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [7:0] accumulator,
    output logic [7:0] mem_wr_data,
    output logic mem_wr_en,
    output logic acc_wr_en,
    output logic skip_req,
    output logic dummy_cycle
);
    rsse_pkg::state_t q;
    rsse_pkg::state_t next_q;
    logic do_wr;
    logic exec_fire;
    logic [`RSSE_ADDR_W-1:0] wr_addr;
    logic [`RSSE_ADDR_W-1:0] rd_addr;
    logic wr_mapped;
    logic rd_mapped;
    logic [8:0] sub_full;
    logic [4:0] sub_low;
    logic [7:0] dec_val;
    logic [7:0] sub_res;
    rsse_pkg::op_t wr_op;

    always_comb begin
        next_q = q;
        next_q.skip_req = 1'b0;
        next_q.mem_wr_en = 1'b0;
        next_q.acc_wr_en = 1'b0;
        next_q.dummy_cycle = 1'b0;
        wr_op = rsse_pkg::op_t'(q.wdata[`RSSE_OP_MSB:`RSSE_OP_LSB]);
        // borrow chain: the 9th bit set means the true result went negative
        sub_full = {1'b0, q.accumulator} - {1'b0, q.mem} - {8'h00, ~q.carry_flag};
        sub_low = {1'b0, q.accumulator[3:0]} - {1'b0, q.mem[3:0]} - {4'h0, ~q.carry_flag};
        sub_res = sub_full[7:0];
        dec_val = q.mem - 8'h01;

        // write channel side
        if (q.bvalid && s_axi_bready) begin
            next_q.bvalid = 1'b0;
        end
        if (s_axi_awvalid && q.awready) begin
            next_q.aw_held = 1'b1;
            next_q.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            next_q.w_held = 1'b1;
            next_q.wdata = s_axi_wdata[7:0];
            next_q.wlane0 = s_axi_wstrb[0];
        end
        wr_addr = {q.awaddr[`RSSE_ADDR_W-1:2], 2'h0};
        wr_mapped = (wr_addr == `RSSE_OFF_OP) || (wr_addr == `RSSE_OFF_ACC) ||
            (wr_addr == `RSSE_OFF_MEM) || (wr_addr == `RSSE_OFF_FLAGS) ||
            (wr_addr == `RSSE_OFF_SKIPS);
        // both halves held in the previous cycle, response slot free
        do_wr = q.aw_held && q.w_held && !q.bvalid;
        exec_fire = do_wr && q.wlane0 && (wr_addr == `RSSE_OFF_OP) &&
            (q.fsm == rsse_pkg::FSM_IDLE);

        if (q.fsm == rsse_pkg::FSM_DUMMY) begin
            next_q.fsm = rsse_pkg::FSM_IDLE;
        end

        if (do_wr) begin
            next_q.aw_held = 1'b0;
            next_q.w_held = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = wr_mapped ? `RSSE_RESP_OKAY : `RSSE_RESP_SLVERR;
            if (q.wlane0) begin
                case (wr_addr)
                    `RSSE_OFF_ACC: begin
                        next_q.accumulator = q.wdata;
                    end
                    `RSSE_OFF_MEM: begin
                        next_q.mem = q.wdata;
                    end
                    `RSSE_OFF_FLAGS: begin
                        next_q.carry_flag = q.wdata[`RSSE_C_BIT];
                        next_q.aux_carry_flag = q.wdata[`RSSE_AC_BIT];
                        next_q.zero_flag = q.wdata[`RSSE_Z_BIT];
                        next_q.overflow_flag = q.wdata[`RSSE_OV_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // an opcode write while fsm is FSM_DUMMY, in the skip pulse cycle, is answered but not executed
        if (exec_fire) begin
            next_q.op = wr_op;
            case (wr_op)
                rsse_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
                    next_q.accumulator = {q.carry_flag, q.mem[7:1]};
                    next_q.carry_flag = q.mem[0];
                    next_q.acc_wr_en = 1'b1;
                end
                rsse_pkg::OP_SUB_BORROW_TO_ACC, rsse_pkg::OP_SUB_BORROW_TO_MEM: begin
                    if (wr_op == rsse_pkg::OP_SUB_BORROW_TO_ACC) begin
                        next_q.accumulator = sub_res;
                        next_q.acc_wr_en = 1'b1;
                    end else begin
                        next_q.mem = sub_res;
                        next_q.mem_wr_en = 1'b1;
                    end
                    next_q.carry_flag = ~sub_full[8];
                    next_q.zero_flag = (sub_res == 8'h00);
                    next_q.aux_carry_flag = ~sub_low[4];
                    next_q.overflow_flag = (q.accumulator[7] ^ q.mem[7]) &
                        (q.accumulator[7] ^ sub_res[7]);
                end
                rsse_pkg::OP_DEC_SKIP_ZERO_MEM, rsse_pkg::OP_DEC_SKIP_ZERO_TO_ACC: begin
                    if (wr_op == rsse_pkg::OP_DEC_SKIP_ZERO_MEM) begin
                        next_q.mem = dec_val;
                        next_q.mem_wr_en = 1'b1;
                    end else begin
                        next_q.accumulator = dec_val;
                        next_q.acc_wr_en = 1'b1;
                    end
                    if (dec_val == 8'h00) begin
                        next_q.skip_req = 1'b1;
                        next_q.fsm = rsse_pkg::FSM_DUMMY;
                        next_q.skip_count = q.skip_count + 8'h01;
                    end
                end
                default: begin
                end
            endcase
        end
        // the dummy cycle follows the skip pulse by one clock
        next_q.dummy_cycle = (q.fsm == rsse_pkg::FSM_DUMMY);

        // read channel side
        if (q.rvalid && s_axi_rready) begin
            next_q.rvalid = 1'b0;
        end
        rd_addr = {s_axi_araddr[`RSSE_ADDR_W-1:2], 2'h0};
        rd_mapped = 1'b1;
        if (s_axi_arvalid && q.arready) begin
            next_q.rvalid = 1'b1;
            next_q.rdata = 32'h0000_0000;
            case (rd_addr)
                `RSSE_OFF_OP: begin
                    next_q.rdata[`RSSE_OP_MSB:`RSSE_OP_LSB] = q.op;
                    next_q.rdata[`RSSE_BUSY_BIT] = (q.fsm == rsse_pkg::FSM_DUMMY);
                end
                `RSSE_OFF_ACC: begin
                    next_q.rdata[7:0] = q.accumulator;
                end
                `RSSE_OFF_MEM: begin
                    next_q.rdata[7:0] = q.mem;
                end
                `RSSE_OFF_FLAGS: begin
                    next_q.rdata[`RSSE_C_BIT] = q.carry_flag;
                    next_q.rdata[`RSSE_AC_BIT] = q.aux_carry_flag;
                    next_q.rdata[`RSSE_Z_BIT] = q.zero_flag;
                    next_q.rdata[`RSSE_OV_BIT] = q.overflow_flag;
                end
                `RSSE_OFF_SKIPS: begin
                    next_q.rdata[7:0] = q.skip_count;
                end
                default: begin
                    rd_mapped = 1'b0;
                end
            endcase
            next_q.rresp = rd_mapped ? `RSSE_RESP_OKAY : `RSSE_RESP_SLVERR;
        end

        // readies are registered, so each channel takes one item per transfer
        next_q.awready = !next_q.aw_held && !next_q.bvalid;
        next_q.wready = !next_q.w_held && !next_q.bvalid;
        next_q.arready = !next_q.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.accumulator <= `RSSE_ACC_RST;
            q.mem <= `RSSE_MEM_RST;
            q.carry_flag <= `RSSE_FLAG_RST;
            q.aux_carry_flag <= `RSSE_FLAG_RST;
            q.zero_flag <= `RSSE_FLAG_RST;
            q.overflow_flag <= `RSSE_FLAG_RST;
            q.op <= rsse_pkg::OP_NONE;
            q.fsm <= rsse_pkg::FSM_IDLE;
        end else begin
            q <= next_q;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bresp = q.bresp;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rvalid = q.rvalid;
    assign accumulator = q.accumulator;
    assign mem_wr_data = q.mem;
    assign mem_wr_en = q.mem_wr_en;
    assign acc_wr_en = q.acc_wr_en;
    assign skip_req = q.skip_req;
    assign dummy_cycle = q.dummy_cycle;

    // checks
    logic fire_rot;
    logic fire_sub;
    logic fire_dec;
    logic [8:0] sub_signed;
    // only an executed opcode write raises the pulses, so each fire mirrors exec_fire
    assign fire_rot = exec_fire && (wr_op == rsse_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC);
    assign fire_sub = exec_fire && ((wr_op == rsse_pkg::OP_SUB_BORROW_TO_ACC) ||
        (wr_op == rsse_pkg::OP_SUB_BORROW_TO_MEM));
    assign fire_dec = exec_fire && ((wr_op == rsse_pkg::OP_DEC_SKIP_ZERO_MEM) ||
        (wr_op == rsse_pkg::OP_DEC_SKIP_ZERO_TO_ACC));
    // signed copy of the subtraction, kept apart from the datapath's xor form of overflow
    assign sub_signed = {q.accumulator[7], q.accumulator} - {q.mem[7], q.mem} -
        {8'h00, ~q.carry_flag};

    // checks look at registered state, so each consequent after a fire starts one clock later; AST_DUMMY starts on the skip pulse itself

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_ROT_ACC: assert property (fire_rot |=>
        q.accumulator == {$past(q.carry_flag), $past(q.mem[7:1])})
        else $error("rotate result wrong");
    AST_ROT_FLAGS: assert property (fire_rot |=>
        q.carry_flag == $past(q.mem[0]) && $stable(q.mem) && $stable(q.zero_flag) &&
        $stable(q.overflow_flag) && $stable(q.aux_carry_flag))
        else $error("rotate flag or memory wrong");
    AST_SUB_ACC: assert property (fire_sub && wr_op == rsse_pkg::OP_SUB_BORROW_TO_ACC |=>
        acc_wr_en && q.accumulator == $past(q.accumulator) - $past(q.mem) -
        {7'h00, ~$past(q.carry_flag)} && $stable(q.mem))
        else $error("subtract to acc wrong");
    AST_SUB_MEM: assert property (fire_sub && wr_op == rsse_pkg::OP_SUB_BORROW_TO_MEM |=>
        mem_wr_en && !acc_wr_en && $stable(q.accumulator) &&
        mem_wr_data == $past(q.accumulator) - $past(q.mem) - {7'h00, ~$past(q.carry_flag)})
        else $error("subtract to memory wrong");
    AST_SUB_CARRY: assert property (fire_sub |=>
        q.carry_flag == ({1'b0, $past(q.accumulator)} >=
        {1'b0, $past(q.mem)} + {8'h00, ~$past(q.carry_flag)}))
        else $error("borrow carry wrong");
    AST_DEC_MEM: assert property (fire_dec && wr_op == rsse_pkg::OP_DEC_SKIP_ZERO_MEM |=>
        mem_wr_en && mem_wr_data == $past(q.mem) - 8'h01 && $stable(q.carry_flag) &&
        $stable(q.zero_flag) && skip_req == (mem_wr_data == 8'h00))
        else $error("decrement memory wrong");
    AST_DEC_ACC: assert property (fire_dec && wr_op == rsse_pkg::OP_DEC_SKIP_ZERO_TO_ACC |=>
        acc_wr_en && !mem_wr_en && $stable(q.mem) && $stable(q.overflow_flag) &&
        skip_req == (q.accumulator == 8'h00))
        else $error("decrement to acc wrong");
    AST_DUMMY: assert property (skip_req |-> !dummy_cycle ##1 dummy_cycle ##1 !dummy_cycle)
        else $error("dummy cycle not exactly one after skip");
    AST_NO_SKIP: assert property (fire_dec && dec_val != 8'h00 |=> !skip_req [*2])
        else $error("skip on non-zero result");
    AST_SUB_ZERO: assert property (fire_sub |=>
        q.zero_flag == ($past(sub_res) == 8'h00) && q.aux_carry_flag == ~$past(sub_low[4]))
        else $error("zero or aux carry wrong");
    AST_SUB_OV: assert property (fire_sub |=>
        q.overflow_flag == ($past(sub_signed[8]) ^ $past(sub_signed[7])))
        else $error("overflow flag wrong");
    AST_SKIP_PULSE: assert property (skip_req |=>
        !skip_req && q.fsm == rsse_pkg::FSM_IDLE)
        else $error("skip held longer than one cycle");

    COV_ROT: cover property (fire_rot ##1 q.carry_flag);
    COV_SUB_NEG: cover property (fire_sub ##1 !q.carry_flag && q.overflow_flag);
    COV_SKIP: cover property (fire_dec ##1 skip_req ##1 dummy_cycle);
    COV_SUB_ZERO: cover property (fire_sub ##1 q.zero_flag);
endmodule
`default_nettype wire

// file: dv/seq_mem_model.sv
// partner model: instruction sequencer and data memory beside the datapath
// assumes one clock and the datapath's one-cycle write and skip pulses
`timescale 1ns/1ps
`default_nettype none
module seq_mem_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] mem_wr_data,
    input wire logic mem_wr_en,
    input wire logic acc_wr_en,
    input wire logic skip_req,
    input wire logic dummy_cycle,
    output logic [7:0] mem_last,
    output logic [7:0] skips,
    output logic [7:0] acc_writes,
    output logic [7:0] order_errs
);
    logic skip_seen;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_last <= 8'h00;
            skips <= 8'h00;
            acc_writes <= 8'h00;
            order_errs <= 8'h00;
            skip_seen <= 1'b0;
        end else begin
            if (mem_wr_en) begin
                mem_last <= mem_wr_data;
            end
            if (acc_wr_en) begin
                acc_writes <= acc_writes + 8'h01;
            end
            if (skip_req) begin
                skips <= skips + 8'h01;
            end
            skip_seen <= skip_req;
            // next fetch happens in the dummy slot, so it must follow a skip at once
            if (dummy_cycle !== skip_seen) begin
                order_errs <= order_errs + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/rotate_subtract_skip_exec_tb_top.sv
// table-driven bench for the execution datapath over axi4-lite
// assumes rsse_pkg compiled first and rsse_defs.svh on the include path
`timescale 1ns/1ps
`include "rsse_defs.svh"
`default_nettype none
module rotate_subtract_skip_exec_tb_top;
    typedef struct packed {
        logic [2:0] op; logic [7:0] a; logic [7:0] m; logic [3:0] f;
        logic [7:0] ea; logic [7:0] em; logic [3:0] ef; logic es;
    } row_t;
    localparam logic [2:0] ROT = rsse_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC;
    localparam logic [2:0] SBA = rsse_pkg::OP_SUB_BORROW_TO_ACC;
    localparam logic [2:0] SBM = rsse_pkg::OP_SUB_BORROW_TO_MEM;
    localparam logic [2:0] DZM = rsse_pkg::OP_DEC_SKIP_ZERO_MEM;
    localparam logic [2:0] DZA = rsse_pkg::OP_DEC_SKIP_ZERO_TO_ACC;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic [7:0] accumulator, mem_wr_data, mem_last, skips, acc_writes, order_errs;
    logic mem_wr_en, acc_wr_en, skip_req, dummy_cycle;
    logic [7:0] exp_skips = 8'h00;
    logic [7:0] exp_accw = 8'h00;
    int failures = 0;
    int comparisons = 0;
    row_t rows [13];
    always #50 aclk = ~aclk;
    rotate_subtract_skip_exec u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .accumulator, .mem_wr_data, .mem_wr_en, .acc_wr_en, .skip_req, .dummy_cycle);
    seq_mem_model u_partner (.aclk, .aresetn, .mem_wr_data, .mem_wr_en, .acc_wr_en,
        .skip_req, .dummy_cycle, .mem_last, .skips, .acc_writes, .order_errs);
    task automatic summarize();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
        cmp_data({30'h0000_0000, g}, {30'h0000_0000, e});
    endtask
    // 2'h3 is never answered, so it marks a reply still outstanding
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (n < 40 && r === 2'h3) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid === 1'b1 && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid === 1'b1 && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        if (r === 2'h3) begin
            failures++;
            summarize();
        end
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (n < 40 && r === 2'h3) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid === 1'b1 && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                r = s_axi_rresp;
                d = s_axi_rdata;
                s_axi_rready <= 1'b0;
            end
        end
        if (r === 2'h3) begin
            failures++;
            summarize();
        end
    endtask
    task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
        axi_read(a, rd, resp);
        cmp_resp(resp, `RSSE_RESP_OKAY);
        cmp_data(rd, {24'h00_0000, e});
    endtask
    initial begin
        rows[0] = '{ROT, 8'h00, 8'hA5, 4'h5, 8'hD2, 8'hA5, 4'h5, 1'b0};
        rows[1] = '{ROT, 8'h77, 8'h02, 4'hA, 8'h01, 8'h02, 4'hA, 1'b0};
        rows[2] = '{SBA, 8'h10, 8'h01, 4'h1, 8'h0F, 8'h01, 4'h1, 1'b0};
        rows[3] = '{SBA, 8'h05, 8'h05, 4'hE, 8'hFF, 8'h05, 4'h0, 1'b0};
        rows[4] = '{SBA, 8'h80, 8'h01, 4'h1, 8'h7F, 8'h01, 4'h9, 1'b0};
        rows[5] = '{SBM, 8'h33, 8'h22, 4'h1, 8'h33, 8'h11, 4'h3, 1'b0};
        rows[6] = '{SBM, 8'h07, 8'h06, 4'h0, 8'h07, 8'h00, 4'h7, 1'b0};
        rows[7] = '{DZM, 8'h44, 8'h01, 4'h5, 8'h44, 8'h00, 4'h5, 1'b1};
        rows[8] = '{DZM, 8'h44, 8'h00, 4'hA, 8'h44, 8'hFF, 4'hA, 1'b0};
        rows[9] = '{DZA, 8'h99, 8'h01, 4'h3, 8'h00, 8'h01, 4'h3, 1'b1};
        rows[10] = '{DZA, 8'h99, 8'h80, 4'hC, 8'h7F, 8'h80, 4'hC, 1'b0};
        rows[11] = '{SBA, 8'h7F, 8'hFF, 4'h1, 8'h80, 8'hFF, 4'hA, 1'b0};
        rows[12] = '{3'h6, 8'h12, 8'h34, 4'h5, 8'h12, 8'h34, 4'h5, 1'b0};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            axi_write(`RSSE_OFF_ACC, {24'h00_0000, rows[i].a}, 4'h1, resp);
            axi_write(`RSSE_OFF_MEM, {24'h00_0000, rows[i].m}, 4'h1, resp);
            axi_write(`RSSE_OFF_FLAGS, {28'h000_0000, rows[i].f}, 4'h1, resp);
            axi_write(`RSSE_OFF_OP, {29'h0000_0000, rows[i].op}, 4'h1, resp);
            cmp_resp(resp, `RSSE_RESP_OKAY);
            exp_skips = exp_skips + {7'h00, rows[i].es};
            if (rows[i].op == ROT || rows[i].op == SBA || rows[i].op == DZA) exp_accw++;
            check_reg(`RSSE_OFF_ACC, rows[i].ea);
            check_reg(`RSSE_OFF_MEM, rows[i].em);
            check_reg(`RSSE_OFF_FLAGS, {4'h0, rows[i].ef});
            check_reg(`RSSE_OFF_SKIPS, exp_skips);
            check_reg(`RSSE_OFF_OP, {5'h00, rows[i].op});
            cmp_data({24'h00_0000, accumulator}, {24'h00_0000, rows[i].ea});
            cmp_data({24'h00_0000, skips}, {24'h00_0000, exp_skips});
            if (rows[i].op == SBM || rows[i].op == DZM) begin
                cmp_data({24'h00_0000, mem_last}, {24'h00_0000, rows[i].em});
            end
            $display("row %0d done", i);
        end
        cmp_data({24'h00_0000, acc_writes}, {24'h00_0000, exp_accw});
        cmp_data({24'h00_0000, order_errs}, 32'h0000_0000);
        // a cleared byte strobe must leave the accumulator alone
        axi_write(`RSSE_OFF_ACC, 32'h0000_005A, 4'h0, resp);
        check_reg(`RSSE_OFF_ACC, 8'h12);
        axi_write(8'h14, 32'h0000_0001, 4'h1, resp);
        cmp_resp(resp, `RSSE_RESP_SLVERR);
        axi_read(8'h14, rd, resp);
        cmp_resp(resp, `RSSE_RESP_SLVERR);
        cmp_data(rd, 32'h0000_0000);
        $display("strobe and unmapped test done");
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        check_reg(`RSSE_OFF_ACC, `RSSE_ACC_RST);
        check_reg(`RSSE_OFF_MEM, `RSSE_MEM_RST);
        check_reg(`RSSE_OFF_FLAGS, 8'h00);
        check_reg(`RSSE_OFF_SKIPS, 8'h00);
        $display("reset test done");
        summarize();
    end
endmodule
`default_nettype wire
